// ---- src/dsoc_ctrl.sv ----
// Serial port register slave with divider sync gating, output-enable pin
// handling, low encode rate detector and housekeeping oscillator control.
// Assumes serial clock, sync and encode clock are slow against clk.
`timescale 1ns/10ps
`include "dsoc_map.svh"
module dsoc_ctrl
   import dsoc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Serial port
   input wire logic serial_clk,
   input wire logic serial_chip_select_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // Converter side pins
   input wire logic sync_in,
   input wire logic encode_clk_in,
   input wire logic output_enable_pin_n,
   // Controls
   output logic divider_resync,
   output logic outputs_enabled,
   output logic low_rate_detected,
   output logic housekeeping_oscillator_run,
   output logic sdio_pulldown_en
);

   logic [5:0] pins_s;
   logic sclk_s;
   logic csb_n_s;
   logic sdio_s;
   logic sync_s;
   logic enc_s;
   logic oe_n_s;
   logic sclk_d_q;
   logic sync_d_q;
   logic enc_d_q;
   logic sclk_rise;
   logic sclk_fall;
   logic sync_rise;
   logic enc_rise;
   dsoc_spi_state_t state_q;
   logic [3:0] cnt_q;
   logic [15:0] shift_q;
   logic [`DSOC_ADDR_W-1:0] addr_q;
   logic rd_q;
   logic [6:0] rem_q;
   logic wr_en;
   dsoc_byte_t wr_data;
   logic wr_sync;
   logic wr_misc;
   dsoc_byte_t sync_q;
   dsoc_byte_t misc_q;
   logic sync_allowed;
   logic [7:0] period_cnt_q;

   function automatic logic is_addr(input logic [`DSOC_ADDR_W-1:0] a, input logic [`DSOC_ADDR_W-1:0] r);
      is_addr = (a == r);
   endfunction

   dsoc_sync #(.WIDTH(6)) u_sync
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_in({serial_clk, serial_chip_select_n, sdio_in, sync_in, encode_clk_in, output_enable_pin_n}),
      .pin_sync(pins_s)
   );

   assign {sclk_s, csb_n_s, sdio_s, sync_s, enc_s, oe_n_s} = pins_s;

   // Edge detection on synchronised pins
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sclk_d_q <= 1'b0;
         sync_d_q <= 1'b0;
         enc_d_q <= 1'b0;
      end
      else
      begin
         sclk_d_q <= sclk_s;
         sync_d_q <= sync_s;
         enc_d_q <= enc_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d_q & ~csb_n_s;
   assign sclk_fall = ~sclk_s & sclk_d_q & ~csb_n_s;
   assign sync_rise = sync_s & ~sync_d_q;
   assign enc_rise = enc_s & ~enc_d_q;

   // Serial frame: 16-bit header, then bytes with decrementing address
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= ST_HDR;
         cnt_q <= 4'h0;
         shift_q <= 16'h0000;
         addr_q <= '0;
         rd_q <= 1'b0;
      end
      else if (csb_n_s)
      begin
         state_q <= ST_HDR;
         cnt_q <= 4'h0;
      end
      else if (sclk_rise)
      begin
         shift_q <= {shift_q[14:0], sdio_s};
         case (state_q)
            ST_HDR:
            begin
               if (cnt_q == `DSOC_HDR_LAST)
               begin
                  rd_q <= shift_q[14];
                  addr_q <= {shift_q[11:0], sdio_s};
                  state_q <= ST_DATA;
                  cnt_q <= 4'h0;
               end
               else
                  cnt_q <= cnt_q + 4'h1;
            end
            ST_DATA:
            begin
               if (cnt_q == `DSOC_BYTE_LAST)
               begin
                  addr_q <= addr_q - `DSOC_ADDR_W'(1);
                  cnt_q <= 4'h0;
               end
               else
                  cnt_q <= cnt_q + 4'h1;
            end
            default:
               state_q <= ST_HDR;
         endcase
      end
   end

   assign wr_en = sclk_rise & (state_q == ST_DATA) & (cnt_q == `DSOC_BYTE_LAST) & ~rd_q;
   assign wr_data = {shift_q[6:0], sdio_s};
   assign wr_sync = wr_en & is_addr(addr_q, `DSOC_ADDR_SYNC);
   assign wr_misc = wr_en & is_addr(addr_q, `DSOC_ADDR_MISC);

   // Read data shifted out on falling serial clock
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sdio_out <= 1'b0;
         sdio_oe <= 1'b0;
         rem_q <= 7'h00;
      end
      else if (csb_n_s)
         sdio_oe <= 1'b0;
      else if (sclk_fall && state_q == ST_DATA && rd_q)
      begin
         sdio_oe <= 1'b1;
         if (cnt_q == 4'h0)
         begin
            if (is_addr(addr_q, `DSOC_ADDR_SYNC))
               {sdio_out, rem_q} <= sync_q;
            else if (is_addr(addr_q, `DSOC_ADDR_MISC))
               {sdio_out, rem_q} <= misc_q;
            else
               {sdio_out, rem_q} <= 8'h00;
         end
         else
         begin
            sdio_out <= rem_q[6];
            rem_q <= {rem_q[5:0], 1'b0};
         end
      end
   end

   assign sync_allowed = sync_rise & sync_q[`DSOC_SYNC_MASTER] & sync_q[`DSOC_SYNC_DIV_EN];

   // Sync control register
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         sync_q <= `DSOC_SYNC_RESET;
      else if (wr_sync)
         sync_q <= wr_data & `DSOC_SYNC_MASK;
      else if (sync_allowed && sync_q[`DSOC_SYNC_NEXT_ONLY])
         sync_q[`DSOC_SYNC_DIV_EN] <= 1'b0;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         divider_resync <= 1'b0;
      else
         divider_resync <= sync_allowed;
   end

   // Miscellaneous settings register
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         misc_q <= `DSOC_MISC_RESET;
      else if (wr_misc)
         misc_q <= wr_data & `DSOC_MISC_MASK;
   end

   // Low encode rate detector
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         period_cnt_q <= 8'h00;
         low_rate_detected <= 1'b0;
      end
      else if (!misc_q[`DSOC_MISC_DET_EN])
      begin
         period_cnt_q <= 8'h00;
         low_rate_detected <= 1'b0;
      end
      else if (enc_rise)
      begin
         period_cnt_q <= 8'h00;
         low_rate_detected <= (period_cnt_q >= 8'(`DSOC_LOW_RATE_CYCLES));
      end
      else if (period_cnt_q >= 8'(`DSOC_LOW_RATE_CYCLES))
         low_rate_detected <= 1'b1;
      else
         period_cnt_q <= period_cnt_q + 8'h01;
   end

   // Pin controls
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         housekeeping_oscillator_run <= 1'b0;
         outputs_enabled <= 1'b1;
         sdio_pulldown_en <= 1'b1;
      end
      else
      begin
         housekeeping_oscillator_run <= misc_q[`DSOC_MISC_OSC_RUN] | low_rate_detected;
         outputs_enabled <= misc_q[`DSOC_MISC_OE_PIN_EN] ? ~oe_n_s : 1'b1;
         sdio_pulldown_en <= ~misc_q[`DSOC_MISC_PD_DIS];
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_master_gate;
      divider_resync |-> $past(sync_q[`DSOC_SYNC_MASTER]);
   endproperty
   a_master_gate: assert property (p_master_gate) else $error("resync without master enable");

   property p_div_gate;
      !sync_q[`DSOC_SYNC_DIV_EN] |=> !divider_resync;
   endproperty
   a_div_gate: assert property (p_div_gate) else $error("resync with divider enable low");

   property p_continuous;
      (sync_allowed && !sync_q[`DSOC_SYNC_NEXT_ONLY] && !wr_sync) |=> divider_resync && sync_q[`DSOC_SYNC_DIV_EN];
   endproperty
   a_continuous: assert property (p_continuous) else $error("continuous sync lost");

   property p_one_shot;
      (sync_allowed && sync_q[`DSOC_SYNC_NEXT_ONLY] && !wr_sync) |=> divider_resync ##0 !sync_q[`DSOC_SYNC_DIV_EN];
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("one-shot did not clear enable");

   property p_oe_ignored;
      !misc_q[`DSOC_MISC_OE_PIN_EN] |=> outputs_enabled;
   endproperty
   a_oe_ignored: assert property (p_oe_ignored) else $error("pin not ignored");

   property p_oe_used;
      (misc_q[`DSOC_MISC_OE_PIN_EN] && oe_n_s) |=> !outputs_enabled;
   endproperty
   a_oe_used: assert property (p_oe_used) else $error("pin not honoured");

   property p_det_off;
      !misc_q[`DSOC_MISC_DET_EN] |=> !low_rate_detected;
   endproperty
   a_det_off: assert property (p_det_off) else $error("detector active while disabled");

   property p_slow_detect;
      (misc_q[`DSOC_MISC_DET_EN] && !enc_rise)[*8] ##1 (period_cnt_q >= 8'(`DSOC_LOW_RATE_CYCLES))
         |=> low_rate_detected || !misc_q[`DSOC_MISC_DET_EN];
   endproperty
   a_slow_detect: assert property (p_slow_detect) else $error("slow encode not flagged");

   property p_osc_start;
      low_rate_detected |=> housekeeping_oscillator_run;
   endproperty
   a_osc_start: assert property (p_osc_start) else $error("oscillator not started");

   property p_osc_force;
      misc_q[`DSOC_MISC_OSC_RUN] |=> housekeeping_oscillator_run;
   endproperty
   a_osc_force: assert property (p_osc_force) else $error("oscillator not forced");

   property p_pulldown;
      sdio_pulldown_en == !$past(misc_q[`DSOC_MISC_PD_DIS]);
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pull-down control wrong");

   property p_reserved;
      ((sync_q & ~`DSOC_SYNC_MASK) == 8'h00) && ((misc_q & ~`DSOC_MISC_MASK) == 8'h00);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_cov_one_shot;
      sync_allowed && sync_q[`DSOC_SYNC_NEXT_ONLY];
   endproperty
   c_one_shot: cover property (p_cov_one_shot);

   property p_cov_read;
      sclk_fall && rd_q && state_q == ST_DATA;
   endproperty
   c_read: cover property (p_cov_read);

   property p_cov_low_rate;
      $rose(low_rate_detected);
   endproperty
   c_low_rate: cover property (p_cov_low_rate);

endmodule

// ---- src/dsoc_map.svh ----
// Register offsets, field positions, reset values and timing counts
// for the divider sync and housekeeping oscillator control block.
// Assumes a 250 MHz system clock.
`ifndef DSOC_MAP_SVH
`define DSOC_MAP_SVH

`define DSOC_ADDR_W 13
`define DSOC_ADDR_SYNC 13'h100
`define DSOC_ADDR_MISC 13'h101

`define DSOC_SYNC_MASTER 0
`define DSOC_SYNC_DIV_EN 1
`define DSOC_SYNC_NEXT_ONLY 2
`define DSOC_SYNC_MASK 8'h07
`define DSOC_SYNC_RESET 8'h01

`define DSOC_MISC_PD_DIS 0
`define DSOC_MISC_OSC_RUN 2
`define DSOC_MISC_DET_EN 3
`define DSOC_MISC_OE_PIN_EN 7
`define DSOC_MISC_MASK 8'h8D
`define DSOC_MISC_RESET 8'h88

`define DSOC_CLK_PERIOD_NS 4
`define DSOC_LOW_RATE_PERIOD_NS 200
`define DSOC_LOW_RATE_CYCLES (`DSOC_LOW_RATE_PERIOD_NS / `DSOC_CLK_PERIOD_NS)

`define DSOC_HDR_LAST 4'hF
`define DSOC_BYTE_LAST 4'h7

`endif

// ---- src/dsoc_pkg.sv ----
// Types for the divider sync and oscillator control block.
// Assumes nothing of its surroundings.
package dsoc_pkg;

   typedef enum logic {ST_HDR, ST_DATA} dsoc_spi_state_t;

   typedef logic [7:0] dsoc_byte_t;

endpackage

// ---- src/dsoc_sync.sv ----
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level.
`timescale 1ns/10ps
module dsoc_sync
#(
   parameter int WIDTH = 6
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);

   logic [WIDTH-1:0] meta_q;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               meta_q[g] <= 1'b0;
               pin_sync[g] <= 1'b0;
            end
            else
            begin
               meta_q[g] <= pin_in[g];
               pin_sync[g] <= meta_q[g];
            end
         end
      end
   endgenerate

endmodule

// ---- tb/dsoc_host.sv ----
// Host controller model on the serial port: one frame per call.
// Assumes the bench resolves the shared data wire from both enables.
`timescale 1ns/10ps
module dsoc_host
(
   // Clock and wire
   input wire logic clk,
   input wire logic sdio_w,
   // Serial port drive
   output logic serial_clk,
   output logic serial_chip_select_n,
   output logic host_d,
   output logic host_oe
);
   initial
   begin
      serial_clk = 1'b0;
      serial_chip_select_n = 1'b1;
      host_d = 1'b0;
      host_oe = 1'b0;
   end

   // Header then one or two data bytes, MSB first, 8 clk per level
   task automatic xfer(input logic rd, input logic [12:0] addr, input logic [15:0] wd, input int nb,
      output logic [15:0] rdat);
      logic [31:0] sh;
      sh = (nb == 2) ? {rd, 2'b00, addr, wd} : {8'h00, rd, 2'b00, addr, wd[7:0]};
      rdat = 16'h0000;
      @(negedge clk);
      serial_chip_select_n <= 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 8 * nb + 15; i >= 0; i--)
      begin
         host_d <= sh[i];
         host_oe <= !(rd && i < 8 * nb);
         repeat (8) @(negedge clk);
         if (i < 8 * nb)
            rdat[i] = sdio_w;
         serial_clk <= 1'b1;
         repeat (8) @(negedge clk);
         serial_clk <= 1'b0;
      end
      host_oe <= 1'b0;
      repeat (8) @(negedge clk);
      // Port left idle between frames
      serial_chip_select_n <= 1'b1;
      repeat (8) @(negedge clk);
   endtask
endmodule

// ---- tb/tb_divider_sync_and_osc_control.sv ----
// Self-checking bench for the sync and oscillator control block.
// Assumes the host model above and a 250 MHz clock.
`timescale 1ns/10ps
`include "dsoc_map.svh"
module tb_divider_sync_and_osc_control
   import dsoc_pkg::*;
;
   logic clk = 1'b0;
   logic encode_clk_in = 1'b0;
   logic sys_rst, serial_clk, serial_chip_select_n, host_d, host_oe, sdio_w, sdio_out, sdio_oe;
   logic sync_in, output_enable_pin_n, enc_on, pin;
   logic divider_resync, outputs_enabled, low_rate_detected, housekeeping_oscillator_run, sdio_pulldown_en;
   logic [15:0] w;
   int mismatches, checks, p0;
   int pulses = 0;
   int enc_cnt = 0;
   int enc_half = 10;
   dsoc_byte_t d, r;

   // Released wire goes low on pull-down, else inverts
   assign sdio_w = sdio_oe ? sdio_out : (host_oe ? host_d : (sdio_pulldown_en ? 1'b0 : ~host_d));

   dsoc_host dsoc_host_i (.clk(clk), .sdio_w(sdio_w), .serial_clk(serial_clk),
      .serial_chip_select_n(serial_chip_select_n), .host_d(host_d), .host_oe(host_oe));

   dsoc_ctrl dsoc_ctrl_i (.clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
      .serial_chip_select_n(serial_chip_select_n), .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .sync_in(sync_in), .encode_clk_in(encode_clk_in), .output_enable_pin_n(output_enable_pin_n),
      .divider_resync(divider_resync), .outputs_enabled(outputs_enabled), .low_rate_detected(low_rate_detected),
      .housekeeping_oscillator_run(housekeeping_oscillator_run), .sdio_pulldown_en(sdio_pulldown_en));

   always #2 clk = ~clk;

   // Encode clock, period twice enc_half clk while running
   always @(negedge clk)
   begin
      if (enc_on && enc_cnt >= enc_half - 1)
      begin
         encode_clk_in <= ~encode_clk_in;
         enc_cnt <= 0;
      end
      else
         enc_cnt <= enc_cnt + 1;
   end

   always @(posedge clk)
      if (divider_resync === 1'b1)
         pulses++;

   function automatic dsoc_byte_t exp_pulses(input logic [2:0] v);
      return (v[0] && v[1]) ? (v[2] ? 8'h01 : 8'h02) : 8'h00;
   endfunction

   function automatic logic exp_oe(input dsoc_byte_t m, input logic pin_n);
      return m[`DSOC_MISC_OE_PIN_EN] ? ~pin_n : 1'b1;
   endfunction

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_byte(input dsoc_byte_t got, input dsoc_byte_t exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [12:0] a, input dsoc_byte_t v);
      logic [15:0] dummy;
      dsoc_host_i.xfer(1'b0, a, {8'h00, v}, 1, dummy);
   endtask

   task automatic rd_chk(input logic [12:0] a, input dsoc_byte_t exp);
      logic [15:0] got;
      dsoc_host_i.xfer(1'b1, a, 16'h0000, 1, got);
      chk_byte(got[7:0], exp);
   endtask

   task automatic pulse();
      @(negedge clk);
      sync_in <= 1'b1;
      repeat (2 + $urandom_range(4)) @(negedge clk);
      sync_in <= 1'b0;
      repeat (20) @(negedge clk);
   endtask

   initial
   begin
      #200000;
      mismatches++;
      tally_and_finish();
   end

   initial
   begin
      sys_rst = 1'b1;
      sync_in = 1'b0;
      output_enable_pin_n = 1'b0;
      enc_on = 1'b1;
      void'($urandom(32'h66EE2077));
      repeat (20) @(negedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk_bit(outputs_enabled, 1'b1);
      chk_bit(sdio_pulldown_en, 1'b1);
      chk_bit(housekeeping_oscillator_run, 1'b0);
      repeat (4) @(negedge clk);
      rd_chk(`DSOC_ADDR_SYNC, `DSOC_SYNC_RESET);
      rd_chk(`DSOC_ADDR_MISC, `DSOC_MISC_RESET);
      rd_chk(13'h102, 8'h00);
      for (int k = 0; k < 6; k++)
      begin
         d = (k == 0) ? 8'hFF : 8'($urandom);
         pin = (k == 0) ? 1'b1 : 1'($urandom);
         output_enable_pin_n <= pin;
         wr(`DSOC_ADDR_MISC, d);
         rd_chk(`DSOC_ADDR_MISC, d & `DSOC_MISC_MASK);
         chk_bit(sdio_pulldown_en, ~d[0]);
         chk_bit(outputs_enabled, exp_oe(d, pin));
         chk_bit(housekeeping_oscillator_run, d[2]);
      end
      wr(`DSOC_ADDR_SYNC, 8'hFF);
      rd_chk(`DSOC_ADDR_SYNC, `DSOC_SYNC_MASK);
      for (int v = 0; v < 8; v++)
      begin
         wr(`DSOC_ADDR_SYNC, 8'(v));
         p0 = pulses;
         pulse();
         pulse();
         chk_byte(8'(pulses - p0), exp_pulses(3'(v)));
         rd_chk(`DSOC_ADDR_SYNC, (v == 7) ? 8'h05 : 8'(v));
      end
      wr(`DSOC_ADDR_MISC, 8'h88);
      enc_on <= 1'b0;
      repeat (80) @(negedge clk);
      chk_bit(low_rate_detected, 1'b1);
      chk_bit(housekeeping_oscillator_run, 1'b1);
      enc_on <= 1'b1;
      repeat (80) @(negedge clk);
      chk_bit(low_rate_detected, 1'b0);
      chk_bit(housekeeping_oscillator_run, 1'b0);
      // Periods of 48 and 52 clk straddle the detector threshold
      enc_half <= 24;
      repeat (200) @(negedge clk);
      chk_bit(low_rate_detected, 1'b0);
      enc_half <= 26;
      repeat (200) @(negedge clk);
      chk_bit(low_rate_detected, 1'b1);
      chk_bit(housekeeping_oscillator_run, 1'b1);
      enc_half <= 10;
      wr(`DSOC_ADDR_MISC, 8'h80);
      enc_on <= 1'b0;
      repeat (80) @(negedge clk);
      chk_bit(low_rate_detected, 1'b0);
      wr(`DSOC_ADDR_MISC, 8'h84);
      chk_bit(housekeeping_oscillator_run, 1'b1);
      // Two-byte frames walk the address down from misc to sync
      d = 8'($urandom);
      r = 8'($urandom);
      dsoc_host_i.xfer(1'b0, `DSOC_ADDR_MISC, {d, r}, 2, w);
      dsoc_host_i.xfer(1'b1, `DSOC_ADDR_MISC, 16'h0000, 2, w);
      chk_byte(w[15:8], d & `DSOC_MISC_MASK);
      chk_byte(w[7:0], r & `DSOC_SYNC_MASK);
      tally_and_finish();
   end
endmodule
